// *** hw/rcs_reset_cause.sv ***
// Purpose: Records reset and wake causes, picks restart address,
//          holds watchdog and low-voltage-detect controls
// Assumes: Core-side event inputs are one-cycle pulses on core_clk
// Notes:   rstn is the power-on reset
//
// Function
// - Power-on sets power-on and brown-out flags, clears others, starts at zero
// - Brown-out sets brown-out, clears power-on, restarts at reset vector
// - Pin reset sets external flag, clears software, watchdog, idle, sleep
// - Reset instruction sets software flag, clears external, watchdog, idle, sleep
// - Pin reset in sleep sets external and sleep, clears watchdog, idle
// - Pin reset in idle sets external and idle, clears watchdog, sleep
// - Watchdog reset sets watchdog flag, clears four others, restarts at zero
// - Interrupt wake from sleep sets sleep flag, resumes at next instruction
// - Enabled interrupt wake loads that interrupt's vector
// - Sleep flag shows the device has been sleeping
// - Idle flag shows the device was idle before the event
// - All cause flags readable and writable; software clears them
// - Software watchdog enable bit turns the watchdog on and off
// - Fuse set keeps the watchdog on regardless of software bit
// - Detector enable bit powers the low-voltage detector up or down
// - Four-bit limit picks a trip level; all ones picks external input
// - Watchdog is a free-running counter that keeps counting; here it counts on core_clk, so a stopped main clock stalls it
// - Watchdog resets the processor when software fails to service it
// - Watchdog time-out resets, except in sleep or idle where it wakes
//
// Design decisions made here: the register addresses and strobed register access.

`timescale 1ns/100ps
`default_nettype none

module rcs_reset_cause
  import rcs_pkg::*;
#(
  parameter int unsigned WDT_TMO_CYC = RCS_WDT_TMO_CYC
) (
  // Clock and power-on reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Register port
  input  wire logic [RCS_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  // Asynchronous supervisory inputs
  input  wire logic                  external_reset_pin_n,
  input  wire logic                  brownout_det,
  // Core state and events
  input  wire logic                  cpu_sleeping,
  input  wire logic                  cpu_idle,
  input  wire logic                  sw_reset_exec,
  input  wire logic                  wdt_clear,
  input  wire logic                  irq_wake,
  input  wire logic                  irq_gie,
  input  wire logic [RCS_PC_W-1:0]   irq_vector,
  input  wire logic                  clk_fail_trap,
  input  wire logic [RCS_PC_W-1:0]   cur_pc,
  input  wire logic                  watchdog_config_fuse,
  // Core control
  output logic                       core_reset,
  output logic                       core_wake,
  output logic                       pc_load,
  output logic      [RCS_PC_W-1:0]   pc_value,
  output logic                       watchdog_running,
  // Low-voltage detector control
  output logic                       lvd_power_en,
  output logic      [3:0]            lvd_level,
  output logic                       lvd_use_ext_input
);

  // ==========================================================
  // Cause decoding
  // ==========================================================
  function automatic rcs_ctrl_t apply_cause(input rcs_ctrl_t f,
                                            input rcs_cause_t c);
    rcs_ctrl_t n;
    n = f;
    unique case (c)
      RCS_C_NONE: begin
      end
      RCS_C_BOR: begin
        n.bor = 1'b1;
        n.por = 1'b0;
      end
      RCS_C_PIN: begin
        n.external_pin_reset_flag  = 1'b1;
        n.software_reset_flag   = 1'b0;
        n.watchdog_timeout_flag  = 1'b0;
        n.idle  = 1'b0;
        n.sleep = 1'b0;
      end
      RCS_C_PIN_SLEEP: begin
        n.external_pin_reset_flag  = 1'b1;
        n.sleep = 1'b1;
        n.watchdog_timeout_flag  = 1'b0;
        n.idle  = 1'b0;
      end
      RCS_C_PIN_IDLE: begin
        n.external_pin_reset_flag  = 1'b1;
        n.idle  = 1'b1;
        n.watchdog_timeout_flag  = 1'b0;
        n.sleep = 1'b0;
      end
      RCS_C_SWR: begin
        n.software_reset_flag   = 1'b1;
        n.external_pin_reset_flag  = 1'b0;
        n.watchdog_timeout_flag  = 1'b0;
        n.idle  = 1'b0;
        n.sleep = 1'b0;
      end
      RCS_C_WDT_RST: begin
        n.watchdog_timeout_flag  = 1'b1;
        n.external_pin_reset_flag  = 1'b0;
        n.software_reset_flag   = 1'b0;
        n.idle  = 1'b0;
        n.sleep = 1'b0;
      end
      RCS_C_WDT_SLEEP: begin
        n.watchdog_timeout_flag  = 1'b1;
        n.sleep = 1'b1;
      end
      RCS_C_WDT_IDLE: begin
        n.watchdog_timeout_flag = 1'b1;
        n.idle = 1'b1;
      end
      RCS_C_IRQ_SLEEP: begin
        n.sleep = 1'b1;
      end
      RCS_C_IRQ_IDLE: begin
        n.idle = 1'b1;
      end
      RCS_C_TRAP: begin
      end
      default: begin
      end
    endcase
    return n;
  endfunction : apply_cause

  // Reset-type causes restart at the reset vector
  function automatic logic is_reset(input rcs_cause_t c);
    return (c == RCS_C_BOR) || (c == RCS_C_PIN) ||
           (c == RCS_C_PIN_SLEEP) || (c == RCS_C_PIN_IDLE) ||
           (c == RCS_C_SWR) || (c == RCS_C_WDT_RST);
  endfunction : is_reset

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Change accepted once stages 2 and 3 agree, which rejects
  // a one-sample glitch on the supervisory lines
  logic [RCS_SYNC_N-1:0] pin_raw;
  logic [RCS_SYNC_N-1:0] pin_filt_q;
  logic [RCS_SYNC_N-1:0] pin_prev_q;

  assign pin_raw = {brownout_det, external_reset_pin_n};

  generate
    for (genvar i = 0; i < RCS_SYNC_N; i++) begin : g_sync
      logic [2:0] sync_q;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          sync_q <= 3'h0;
        end else begin
          sync_q <= {sync_q[1:0], pin_raw[i]};
        end
      end
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          pin_filt_q[i] <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
          pin_filt_q[i] <= sync_q[2];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_filt_q;
    end
  end

  // Pin filter starts low, so a held-high pin gives no false edge
  logic pin_reset_ev;
  logic bor_ev;
  assign pin_reset_ev = pin_prev_q[0] && !pin_filt_q[0];
  assign bor_ev       = !pin_prev_q[1] && pin_filt_q[1];

  // ==========================================================
  // Watchdog
  // ==========================================================
  rcs_ctrl_t            ctrl_q;
  logic [RCS_WDT_W-1:0] wdt_cnt_q;
  logic                 wdt_en;
  logic                 wdt_tmo;

  assign wdt_en  = watchdog_config_fuse || ctrl_q.swdt_en;
  assign wdt_tmo = wdt_en &&
    (wdt_cnt_q == RCS_WDT_W'(WDT_TMO_CYC - 1));

  // Free-running count
  // Runs on core_clk; a stopped main clock stalls it here
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_cnt_q <= '0;
    end else if (!wdt_en || wdt_clear || wdt_tmo ||
                 pin_reset_ev || bor_ev || sw_reset_exec) begin
      wdt_cnt_q <= '0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + RCS_WDT_W'(1);
    end
  end

  // ==========================================================
  // Cause selection
  // ==========================================================
  rcs_cause_t cause;

  always_comb begin
    cause = RCS_C_NONE;
    if (bor_ev) begin
      cause = RCS_C_BOR;
    end else if (pin_reset_ev) begin
      if (cpu_sleeping) begin
        cause = RCS_C_PIN_SLEEP;
      end else if (cpu_idle) begin
        cause = RCS_C_PIN_IDLE;
      end else begin
        cause = RCS_C_PIN;
      end
    end else if (wdt_tmo) begin
      if (cpu_sleeping) begin
        cause = RCS_C_WDT_SLEEP;
      end else if (cpu_idle) begin
        cause = RCS_C_WDT_IDLE;
      end else begin
        cause = RCS_C_WDT_RST;
      end
    end else if (sw_reset_exec) begin
      cause = RCS_C_SWR;
    end else if (irq_wake && cpu_sleeping) begin
      cause = RCS_C_IRQ_SLEEP;
    end else if (irq_wake && cpu_idle) begin
      cause = RCS_C_IRQ_IDLE;
    end else if (clk_fail_trap) begin
      cause = RCS_C_TRAP;
    end
  end

  // ==========================================================
  // Control/status register
  // ==========================================================
  logic      ctrl_sel;
  rcs_ctrl_t ctrl_wr;

  assign ctrl_sel = (reg_addr == RCS_CTRL_OFFS);
  assign ctrl_wr  = rcs_ctrl_t'(reg_wdata & RCS_WR_MASK);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= rcs_ctrl_t'(RCS_POR_VALUE);
    end else if (reg_wr && ctrl_sel) begin
      ctrl_q <= apply_cause(ctrl_wr, cause);
    end else begin
      ctrl_q <= apply_cause(ctrl_q, cause);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && ctrl_sel) begin
      reg_rdata <= ctrl_q & RCS_WR_MASK;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Restart control
  // ==========================================================
  // Restart address: reset vector, trap vector, interrupt vector or next instruction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc_load  <= 1'b1;
      pc_value <= RCS_RESET_VEC;
    end else begin
      pc_load  <= (cause != RCS_C_NONE);
      if (is_reset(cause)) begin
        pc_value <= RCS_RESET_VEC;
      end else if (cause == RCS_C_TRAP) begin
        pc_value <= RCS_TRAP_VEC;
      end else if ((cause == RCS_C_IRQ_SLEEP ||
                    cause == RCS_C_IRQ_IDLE) && irq_gie) begin
        pc_value <= irq_vector;
      end else if (cause != RCS_C_NONE) begin
        pc_value <= cur_pc + RCS_PC_STEP;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_reset <= 1'b1;
      core_wake  <= 1'b0;
    end else begin
      core_reset <= is_reset(cause);
      core_wake  <= (cause == RCS_C_WDT_SLEEP) ||
                    (cause == RCS_C_WDT_IDLE) ||
                    (cause == RCS_C_IRQ_SLEEP) ||
                    (cause == RCS_C_IRQ_IDLE);
    end
  end

  // ==========================================================
  // Status outputs
  // ==========================================================
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_running  <= 1'b0;
      lvd_power_en      <= 1'b0;
      lvd_level         <= 4'h0;
      lvd_use_ext_input <= 1'b0;
    end else begin
      watchdog_running  <= wdt_en;
      lvd_power_en      <= ctrl_q.lvd_en;
      lvd_level         <= ctrl_q.lvd_limit;
      lvd_use_ext_input <= (ctrl_q.lvd_limit == RCS_LIM_EXT);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_por_flags_set: assert property (
    $rose(rstn) |-> ctrl_q.por && ctrl_q.bor && !ctrl_q.external_pin_reset_flag &&
      pc_load && pc_value == RCS_RESET_VEC)
    else $error("power-on flags or vector wrong");

  a_bor_restart: assert property (
    bor_ev |=> ctrl_q.bor && !ctrl_q.por && core_reset &&
      pc_value == RCS_RESET_VEC)
    else $error("brown-out handling wrong");

  a_pin_normal: assert property (
    cause == RCS_C_PIN |=> ctrl_q.external_pin_reset_flag && !ctrl_q.software_reset_flag &&
      !ctrl_q.watchdog_timeout_flag && !ctrl_q.idle && !ctrl_q.sleep &&
      ctrl_q.por == $past(ctrl_q.por))
    else $error("pin reset flags wrong");

  a_swr_flags: assert property (
    cause == RCS_C_SWR |=> ctrl_q.software_reset_flag && !ctrl_q.external_pin_reset_flag &&
      !ctrl_q.watchdog_timeout_flag && !ctrl_q.sleep && core_reset)
    else $error("software reset flags wrong");

  a_pin_sleep: assert property (
    cause == RCS_C_PIN_SLEEP |=> ctrl_q.external_pin_reset_flag && ctrl_q.sleep &&
      !ctrl_q.idle && !ctrl_q.watchdog_timeout_flag)
    else $error("pin reset in sleep wrong");

  a_pin_idle: assert property (
    cause == RCS_C_PIN_IDLE |=> ctrl_q.external_pin_reset_flag && ctrl_q.idle &&
      !ctrl_q.sleep && !ctrl_q.watchdog_timeout_flag)
    else $error("pin reset in idle wrong");

  a_wdt_reset: assert property (
    wdt_tmo && !cpu_sleeping && !cpu_idle && !bor_ev &&
      !pin_reset_ev |=> ctrl_q.watchdog_timeout_flag && !ctrl_q.external_pin_reset_flag &&
      core_reset && pc_value == RCS_RESET_VEC)
    else $error("watchdog reset wrong");

  a_wdt_wake: assert property (
    cause == RCS_C_WDT_SLEEP |=> ctrl_q.watchdog_timeout_flag && ctrl_q.sleep &&
      core_wake && !core_reset &&
      pc_value == $past(cur_pc) + RCS_PC_STEP)
    else $error("watchdog wake wrong");

  a_irq_vector: assert property (
    cause == RCS_C_IRQ_SLEEP && irq_gie |=>
      pc_value == $past(irq_vector) && ctrl_q.sleep && core_wake)
    else $error("interrupt wake target wrong");

  a_wdt_enable: assert property (
    watchdog_config_fuse ##1 watchdog_config_fuse |->
      watchdog_running)
    else $error("fuse did not force watchdog on");

  a_trap_vector: assert property (
    cause == RCS_C_TRAP && !reg_wr |=> pc_value == RCS_TRAP_VEC &&
      ctrl_q == $past(ctrl_q) && !core_reset)
    else $error("clock trap handling wrong");

  a_lvd_ext_sel: assert property (
    ctrl_q.lvd_limit == RCS_LIM_EXT |=> lvd_use_ext_input)
    else $error("external threshold not selected");

endmodule : rcs_reset_cause

`default_nettype wire

// *** hw/rcs_pkg.sv ***
// Purpose: Shared constants and types for the reset-cause status logic
// Assumes: One 16-bit control/status register on a plain register port
// Notes:   Field layout follows the register bit order, bit 15 first

package rcs_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int unsigned RCS_ADDR_W    = 4;
  localparam logic [3:0]  RCS_CTRL_OFFS = 4'h0;
  localparam int unsigned RCS_DATA_W    = 16;

  // Field positions inside the control/status word
  localparam int unsigned RCS_POR_POS   = 0;
  localparam int unsigned RCS_BOR_POS   = 1;
  localparam int unsigned RCS_IDLE_POS  = 2;
  localparam int unsigned RCS_SLEEP_POS = 3;
  localparam int unsigned RCS_WATCHDOG_TIMEOUT_FLAG_POS  = 4;
  localparam int unsigned RCS_SWDT_POS  = 5;
  localparam int unsigned RCS_SWR_POS   = 6;
  localparam int unsigned RCS_EXTERNAL_PIN_RESET_FLAG_POS  = 7;
  localparam int unsigned RCS_LIM_POS   = 8;
  localparam int unsigned RCS_LOW_VOLTAGE_DETECT_ENABLE_POS = 12;

  // Writable bits; 15:13 read as zero
  localparam logic [15:0] RCS_WR_MASK   = 16'h1FFF;
  // Power-on value: power-on and brown-out flags set
  localparam logic [15:0] RCS_POR_VALUE = 16'h0003;
  localparam logic [3:0]  RCS_LIM_EXT   = 4'hF;

  // ==========================================================
  // Program counter targets
  // ==========================================================
  localparam int unsigned RCS_PC_W      = 24;
  localparam logic [23:0] RCS_RESET_VEC = 24'h00_0000;
  localparam logic [23:0] RCS_TRAP_VEC  = 24'h00_0004;
  localparam logic [23:0] RCS_PC_STEP   = 24'h00_0002;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned RCS_CLK_HZ       = 20_000_000;
  localparam int unsigned RCS_WDT_TMO_US   = 2000;
  localparam int unsigned RCS_WDT_TMO_CYC  =
    (RCS_WDT_TMO_US * (RCS_CLK_HZ / 1_000_000));
  localparam int unsigned RCS_WDT_W        = 24;
  localparam int unsigned RCS_SYNC_N       = 2;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       lvd_en;
    logic [3:0] lvd_limit;
    logic       external_pin_reset_flag;
    logic       software_reset_flag;
    logic       swdt_en;
    logic       watchdog_timeout_flag;
    logic       sleep;
    logic       idle;
    logic       bor;
    logic       por;
  } rcs_ctrl_t;

  typedef enum logic [3:0] {
    RCS_C_NONE      = 4'h0,
    RCS_C_BOR       = 4'h1,
    RCS_C_PIN       = 4'h2,
    RCS_C_PIN_SLEEP = 4'h3,
    RCS_C_PIN_IDLE  = 4'h4,
    RCS_C_SWR       = 4'h5,
    RCS_C_WDT_RST   = 4'h6,
    RCS_C_WDT_SLEEP = 4'h7,
    RCS_C_WDT_IDLE  = 4'h8,
    RCS_C_IRQ_SLEEP = 4'h9,
    RCS_C_IRQ_IDLE  = 4'hA,
    RCS_C_TRAP      = 4'hB
  } rcs_cause_t;

endpackage : rcs_pkg

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the reset-cause status logic
// Assumes: Watchdog time-out shortened to 16 cycles for simulation
// Notes:   Inputs move on the rising edge, outputs sampled on the falling

`timescale 1ns/100ps
`default_nettype none

module tb_top
  import rcs_pkg::*;
;
  localparam int TMO = 16;

  // ==========================================================
  // Signals
  // ==========================================================
  logic                  core_clk;
  logic                  rstn;
  logic [RCS_ADDR_W-1:0] reg_addr;
  logic [15:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [15:0]           reg_rdata;
  logic                  pin_n;
  logic                  brownout_det;
  logic                  cpu_sleeping;
  logic                  cpu_idle;
  logic                  sw_reset_exec;
  logic                  wdt_clear;
  logic                  irq_wake;
  logic                  irq_gie;
  logic                  clk_fail_trap;
  logic                  fuse;
  logic                  core_reset;
  logic                  core_wake;
  logic                  pc_load;
  logic [RCS_PC_W-1:0]   pc_value;
  logic                  wdt_run;
  logic                  lvd_power_en;
  logic [3:0]            lvd_level;
  logic                  lvd_ext;
  logic [RCS_PC_W-1:0]   cur_pc;
  logic [RCS_PC_W-1:0]   irq_vector;
  int                    error_cnt;
  int                    n_checks;
  int                    cyc;
  logic [15:0]           rd;

  rcs_reset_cause #(.WDT_TMO_CYC(TMO)) DUT (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_reset_pin_n(pin_n),
    .brownout_det(brownout_det), .cpu_sleeping(cpu_sleeping),
    .cpu_idle(cpu_idle), .sw_reset_exec(sw_reset_exec),
    .wdt_clear(wdt_clear), .irq_wake(irq_wake), .irq_gie(irq_gie),
    .irq_vector(irq_vector), .clk_fail_trap(clk_fail_trap),
    .cur_pc(cur_pc), .watchdog_config_fuse(fuse),
    .core_reset(core_reset), .core_wake(core_wake), .pc_load(pc_load),
    .pc_value(pc_value), .watchdog_running(wdt_run),
    .lvd_power_en(lvd_power_en), .lvd_level(lvd_level),
    .lvd_use_ext_input(lvd_ext)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : reg_read

  task automatic rd_chk(input logic [15:0] exp);
    logic [15:0] d;
    reg_read(4'h0, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  // Kind: 0 reset instruction, 1 interrupt wake, 2 clock trap, 3 service
  task automatic pulse(input int k);
    @(posedge core_clk);
    case (k)
      0: sw_reset_exec <= 1'b1;
      1: irq_wake <= 1'b1;
      2: clk_fail_trap <= 1'b1;
      default: wdt_clear <= 1'b1;
    endcase
    @(posedge core_clk);
    {sw_reset_exec, irq_wake, clk_fail_trap, wdt_clear} <= 4'h0;
  endtask : pulse

  // Bounded wait for the restart pulse, then its reset flag and address
  task automatic wait_evt(input logic r, input logic [23:0] pc);
    int i;
    i = 0;
    @(negedge core_clk);
    while (pc_load !== 1'b1 && i < 40) begin
      @(negedge core_clk);
      i++;
    end
    check({23'h0, pc_load}, 24'h1);
    check({23'h0, core_reset}, {23'h0, r});
    check(pc_value, pc);
  endtask : wait_evt

  task automatic quiet(input int n);
    int ones;
    ones = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (pc_load !== 1'b0) ones++;
    end
    check(ones[23:0], 24'h0);
  endtask : quiet

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    {rstn, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {brownout_det, cpu_sleeping, cpu_idle, sw_reset_exec} = 4'h0;
    {wdt_clear, irq_wake, irq_gie, clk_fail_trap, fuse} = 5'h00;
    pin_n      = 1'b1;
    cur_pc     = 24'h00_1230;
    irq_vector = 24'h00_0140;
    error_cnt  = 0;
    n_checks   = 0;
    cyc        = 0;
    repeat (11) @(posedge core_clk);
    @(negedge core_clk);
    check({22'h0, core_reset, pc_load}, 24'h3);
    check(pc_value, RCS_RESET_VEC);
    @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(RCS_POR_VALUE);
    // Writable bits, reserved bits read zero
    reg_write(4'h0, 16'hFFDF);
    rd_chk(16'h1FDF);
    repeat (2) @(negedge core_clk);
    check({19'h0, lvd_power_en, lvd_level}, 24'h1F);
    check({23'h0, lvd_ext}, 24'h1);
    reg_write(4'h5, 16'h0000);
    rd_chk(16'h1FDF);
    reg_read(4'h5, rd);
    check({8'h00, rd}, 24'h0);
    reg_write(4'h0, 16'h0E00);
    repeat (2) @(negedge core_clk);
    check({18'h0, lvd_ext, lvd_power_en, lvd_level}, 24'h0E);
    // Reset instruction
    reg_write(4'h0, 16'h00DF);
    pulse(0);
    wait_evt(1'b1, RCS_RESET_VEC);
    rd_chk(16'h0043);
    // Pin reset in normal, sleep and idle operation
    reg_write(4'h0, 16'h005F);
    @(posedge core_clk) pin_n <= 1'b0;
    wait_evt(1'b1, RCS_RESET_VEC);
    @(posedge core_clk) pin_n <= 1'b1;
    rd_chk(16'h0083);
    repeat (6) @(posedge core_clk);
    cpu_sleeping <= 1'b1;
    reg_write(4'h0, 16'h0054);
    @(posedge core_clk) pin_n <= 1'b0;
    wait_evt(1'b1, RCS_RESET_VEC);
    @(posedge core_clk) pin_n <= 1'b1;
    cpu_sleeping <= 1'b0;
    rd_chk(16'h00C8);
    repeat (6) @(posedge core_clk);
    cpu_idle <= 1'b1;
    reg_write(4'h0, 16'h0058);
    @(posedge core_clk) pin_n <= 1'b0;
    wait_evt(1'b1, RCS_RESET_VEC);
    @(posedge core_clk) pin_n <= 1'b1;
    cpu_idle <= 1'b0;
    rd_chk(16'h00C4);
    // Brown-out clears power-on, keeps other cause flags
    reg_write(4'h0, 16'h00D1);
    @(posedge core_clk) brownout_det <= 1'b1;
    wait_evt(1'b1, RCS_RESET_VEC);
    @(posedge core_clk) brownout_det <= 1'b0;
    rd_chk(16'h00D2);
    // Interrupt wake: ignored when running, next instruction, vector
    reg_write(4'h0, 16'h0000);
    pulse(1);
    quiet(6);
    rd_chk(16'h0000);
    @(posedge core_clk) cpu_sleeping <= 1'b1;
    pulse(1);
    wait_evt(1'b0, cur_pc + RCS_PC_STEP);
    check({23'h0, core_wake}, 24'h1);
    @(posedge core_clk) cpu_sleeping <= 1'b0;
    rd_chk(16'h0008);
    reg_write(4'h0, 16'h0000);
    cpu_idle <= 1'b1;
    irq_gie  <= 1'b1;
    pulse(1);
    wait_evt(1'b0, irq_vector);
    @(posedge core_clk) cpu_idle <= 1'b0;
    irq_gie  <= 1'b0;
    rd_chk(16'h0004);
    // Enabled interrupt wake from sleep takes its vector
    @(posedge core_clk) cpu_sleeping <= 1'b1;
    irq_gie  <= 1'b1;
    pulse(1);
    wait_evt(1'b0, irq_vector);
    check({23'h0, core_wake}, 24'h1);
    @(posedge core_clk) cpu_sleeping <= 1'b0;
    irq_gie  <= 1'b0;
    rd_chk(16'h000C);
    // Clock trap leaves every flag alone
    reg_write(4'h0, 16'h00DF);
    pulse(2);
    wait_evt(1'b0, RCS_TRAP_VEC);
    rd_chk(16'h00DF);
    // Fuse forces the watchdog on; servicing holds off the time-out
    reg_write(4'h0, 16'h00C3);
    pulse(3);
    fuse <= 1'b1;
    repeat (2) @(negedge core_clk);
    check({23'h0, wdt_run}, 24'h1);
    repeat (6) begin
      pulse(3);
      quiet(6);
    end
    wait_evt(1'b1, RCS_RESET_VEC);
    @(posedge core_clk) fuse <= 1'b0;
    rd_chk(16'h0013);
    // Software enable, time-out in sleep wakes instead of resetting
    pulse(3);
    cpu_sleeping <= 1'b1;
    reg_write(4'h0, 16'h00E3);
    repeat (2) @(negedge core_clk);
    check({23'h0, wdt_run}, 24'h1);
    wait_evt(1'b0, cur_pc + RCS_PC_STEP);
    check({23'h0, core_wake}, 24'h1);
    @(posedge core_clk) cpu_sleeping <= 1'b0;
    rd_chk(16'h00FB);
    reg_write(4'h0, 16'h0000);
    repeat (2) @(negedge core_clk);
    check({23'h0, wdt_run}, 24'h0);
    stop_test();
  end

endmodule : tb_top

`default_nettype wire
